// File: dv/lirm_tb.sv
// self-checking testbench for the legacy register mapping block
`timescale 1ns/100ps
`default_nettype none
module lirm_tb;
    import lirm_pkg::*;
    logic clk = 1'b0, rst = 1'b1, leg = 1'b0;
    logic [IDX_W-1:0] ird = '0, frd = '0;
    lirm_int_wr_s iwr = '0;
    lirm_flt_wr_s fwr = '0;
    lirm_leg_sel_e lsel = LS_ACCUMULATOR;
    lirm_leg_wr_s lwr = '0;
    lirm_scr_wr_s swr = '0;
    lirm_ip_wr_s ipw = '0;
    logic [INT_W-1:0] ird_q, lrd_q, ip_q;
    logic [FLT_W-1:0] frd_q;
    logic ref_q;
    int fails = 0, num_checks = 0, cyc = 0;
    lirm_regfile lirm_regfile_i (.REF_CLK_I(clk), .RST_I(rst), .LEGACY_MODE_I(leg), .NAT_INT_RD_IDX_I(ird),
        .NAT_INT_WR_I(iwr), .NAT_FLT_RD_IDX_I(frd), .NAT_FLT_WR_I(fwr), .LEG_RD_SEL_I(lsel), .LEG_WR_I(lwr),
        .LEG_SCR_WR_I(swr), .IP_WR_I(ipw), .NAT_INT_RD_DATA_O(ird_q), .NAT_FLT_RD_DATA_O(frd_q),
        .LEG_RD_DATA_O(lrd_q), .IP_O(ip_q), .REFUSED_O(ref_q));
    // 10 MHz clock and a hang limit
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // comparisons of data words and of single flags
    task automatic chk(input logic [FLT_W-1:0] e, input logic [FLT_W-1:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_bit(input logic e, input logic g);
        chk({81'h0, e}, {81'h0, g});
    endtask
    task automatic tick();
        @(negedge clk);
    endtask
    // write drivers: one strobe, the refusal flag of that write is judged, then one idle cycle
    task automatic nat_wr(input int i, input logic [63:0] d, input logic r);
        iwr = '{1'b1, 7'(i), d};
        tick();
        iwr.en = 1'b0;
        chk_bit(r, ref_q);
        tick();
    endtask
    task automatic flt_wr(input int i, input logic [81:0] d, input logic r);
        fwr = '{1'b1, 7'(i), d};
        tick();
        fwr.en = 1'b0;
        chk_bit(r, ref_q);
        tick();
    endtask
    task automatic leg_wr(input int c, input logic [63:0] d, input logic r);
        lwr = '{1'b1, lirm_leg_sel_e'(5'(c)), d};
        tick();
        lwr.en = 1'b0;
        chk_bit(r, ref_q);
        tick();
    endtask
    task automatic scr_wr(input logic f, input int i, input logic r);
        swr = '{1'b1, f, 7'(i), 82'h2_5a5a_0000_1111_2222};
        tick();
        swr.en = 1'b0;
        chk_bit(r, ref_q);
        tick();
    endtask
    // read drivers: index at one falling edge, answer one cycle later
    task automatic rd_int(input int i, input logic [63:0] e);
        ird = 7'(i);
        tick();
        chk({18'h0, e}, {18'h0, ird_q});
    endtask
    task automatic rd_flt(input int i, input logic [81:0] e);
        frd = 7'(i);
        tick();
        chk(e, frd_q);
    endtask
    task automatic rd_leg(input int c, input logic [63:0] e);
        lsel = lirm_leg_sel_e'(5'(c));
        tick();
        chk({18'h0, e}, {18'h0, lrd_q});
    endtask
    // distinct 16-bit fields per native word
    function automatic logic [63:0] val(input int i);
        return {16'(i) + 16'h4000, 16'(i) + 16'h3000, 16'(i) + 16'h2000, 16'(i) + 16'h1000};
    endfunction
    // native fill, then every legacy select read back from its native home
    task automatic t_map();
        int idx, sh;
        logic [63:0] m;
        for (int i = 8; i < 32; i++) nat_wr(i, val(i), 1'b0);
        leg = 1'b1;
        for (int c = 0; c < 32; c++) begin
            idx = (c < 8) ? 8 + c : (c < 16) ? 16 + c / 12 : (c == 16) ? 24 : 10 + c;
            sh = (c >= 8 && c < 16) ? (c % 4) * 16 : 0;
            m = (c < 8) ? 64'hffff_ffff : (c < 16) ? 64'hffff : 64'hffff_ffff_ffff_ffff;
            rd_leg(c, (c < 22) ? (val(idx) >> sh) & m : 64'h0);
        end
    endtask
    // legacy writes, refusals, stack pointer and the shared instruction pointer
    task automatic t_legacy();
        leg_wr(0, 64'hffff_ffff_dead_beef, 1'b0);
        rd_int(8, (val(8) & 64'hffff_ffff_0000_0000) | 64'hdead_beef);
        leg_wr(11, 64'h1234_5678_9abc_abcd, 1'b0);
        rd_int(16, (val(16) & 64'h0000_ffff_ffff_ffff) | 64'habcd_0000_0000_0000);
        leg_wr(9, 64'h0000_0000_0000_5555, 1'b0);
        rd_int(16, (val(16) & 64'h0000_ffff_0000_ffff) | 64'habcd_0000_5555_0000);
        chk_bit(1'b0, ref_q);
        leg_wr(22, 64'h1, 1'b1);
        nat_wr(9, 64'h0, 1'b1);
        rd_int(9, val(9));
        chk_bit(1'b0, ref_q);
        leg_wr(4, 64'h0000_0000_0bad_f00d, 1'b0);
        rd_int(12, (val(12) & 64'hffff_ffff_0000_0000) | 64'h0bad_f00d);
        ipw = '{1'b1, 64'h0000_0000_0040_1000};
        tick();
        ipw.en = 1'b0;
        chk_bit(1'b0, ref_q);
        tick();
        chk({18'h0, 64'h0040_1000}, {18'h0, ip_q});
        leg = 1'b0;
        tick();
        chk({18'h0, 64'h0040_1000}, {18'h0, ip_q});
        leg_wr(1, 64'h7, 1'b1);
    endtask
    // scratch areas may be used, preserved areas are never touched by legacy execution
    task automatic t_scratch();
        int ok[8] = '{1, 3, 18, 23, 25, 26, 32, 127};
        int bad[4] = '{4, 7, 8, 0};
        nat_wr(4, 64'h4444, 1'b0);
        flt_wr(3, 82'h3_3333, 1'b0);
        flt_wr(1, 82'h0, 1'b0);
        nat_wr(0, 64'hff, 1'b0);
        scr_wr(1'b0, 2, 1'b1);
        leg = 1'b1;
        nat_wr(4, 64'h0, 1'b1);
        foreach (ok[k]) scr_wr(1'b0, ok[k], 1'b0);
        foreach (bad[k]) scr_wr(1'b0, bad[k], 1'b1);
        scr_wr(1'b1, 6, 1'b0);
        scr_wr(1'b1, 7, 1'b0);
        scr_wr(1'b1, 3, 1'b1);
        rd_int(4, 64'h4444);
        rd_flt(3, 82'h3_3333);
        rd_int(0, 64'h0);
        rd_flt(0, FLT_ZERO);
        rd_flt(1, FLT_ONE);
        leg = 1'b0;
        rd_flt(1, FLT_ONE);
        rd_flt(0, FLT_ZERO);
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (10) tick();
        rst = 1'b0;
        tick();
        rd_int(8, 64'h0);
        chk_bit(1'b0, ref_q);
        t_map();
        t_legacy();
        t_scratch();
        report_and_stop();
    end
endmodule
`default_nettype wire

// File: rtl/lirm_conv.sv
// convention classifier for native integer and float register indices
`timescale 1ns/100ps
`default_nettype none
module lirm_conv (
    input wire logic [lirm_pkg::IDX_W-1:0] int_idx_i,  // native integer index
    input wire logic [lirm_pkg::IDX_W-1:0] flt_idx_i,  // native float index
    output var lirm_pkg::lirm_conv_e int_conv_o,      // integer convention
    output var lirm_pkg::lirm_conv_e flt_conv_o       // float convention
);
    import lirm_pkg::*;

    // integer register conventions by range
    always_comb begin
        if (int_idx_i == IDX_ZERO) begin
            int_conv_o = CONV_CONST;
        end else if (int_idx_i <= IDX_SCR_A_HI) begin
            int_conv_o = CONV_UNDEF;
        end else if (int_idx_i <= IDX_UNMOD_HI) begin
            int_conv_o = CONV_UNMOD;
        end else if (int_idx_i == IDX_LEG_SP) begin
            int_conv_o = CONV_SHARED;
        end else if (int_idx_i <= IDX_SEL_CODE) begin
            int_conv_o = CONV_LEGACY;
        end else if (int_idx_i <= IDX_SCR_B_HI) begin
            int_conv_o = CONV_UNDEF;
        end else if (int_idx_i == IDX_DESC_EXTRA) begin
            int_conv_o = CONV_LEGACY;
        end else if (int_idx_i <= IDX_SCR_C_HI) begin
            int_conv_o = CONV_UNDEF;
        end else if (int_idx_i <= IDX_DESC_HI) begin
            int_conv_o = CONV_LEGACY;
        end else begin
            int_conv_o = CONV_UNDEF;
        end
    end

    // float register conventions; the legacy float stack is kept outside
    always_comb begin
        if (flt_idx_i <= FIDX_ONE) begin
            flt_conv_o = CONV_CONST;
        end else if (flt_idx_i <= FIDX_UNMOD_HI) begin
            flt_conv_o = CONV_UNMOD;
        end else if (flt_idx_i <= FIDX_SCR_HI) begin
            flt_conv_o = CONV_UNDEF;
        end else if (flt_idx_i < FIDX_EXEC_LO) begin
            flt_conv_o = CONV_OUTSIDE;
        end else begin
            flt_conv_o = CONV_UNDEF;
        end
    end

endmodule
`default_nettype wire

// File: rtl/lirm_regfile.sv
// shared native and legacy register file with convention-checked access ports
`timescale 1ns/100ps
`default_nettype none
module lirm_regfile (
    input wire logic REF_CLK_I,                             // core clock, 10 MHz
    input wire logic RST_I,                                 // synchronous reset, active high
    input wire logic LEGACY_MODE_I,                         // high while the legacy set executes
    input wire logic [lirm_pkg::IDX_W-1:0] NAT_INT_RD_IDX_I, // native integer read index
    input wire lirm_pkg::lirm_int_wr_s NAT_INT_WR_I,         // native integer write
    input wire logic [lirm_pkg::IDX_W-1:0] NAT_FLT_RD_IDX_I, // native float read index
    input wire lirm_pkg::lirm_flt_wr_s NAT_FLT_WR_I,         // native float write
    input wire lirm_pkg::lirm_leg_sel_e LEG_RD_SEL_I,        // legacy read select
    input wire lirm_pkg::lirm_leg_wr_s LEG_WR_I,             // legacy register write
    input wire lirm_pkg::lirm_scr_wr_s LEG_SCR_WR_I,         // legacy scratch write
    input wire lirm_pkg::lirm_ip_wr_s IP_WR_I,               // instruction pointer write
    output logic [lirm_pkg::INT_W-1:0] NAT_INT_RD_DATA_O,    // native integer read data
    output logic [lirm_pkg::FLT_W-1:0] NAT_FLT_RD_DATA_O,    // native float read data
    output logic [lirm_pkg::INT_W-1:0] LEG_RD_DATA_O,        // legacy read data
    output logic [lirm_pkg::INT_W-1:0] IP_O,                 // shared instruction pointer
    output logic REFUSED_O                                   // pulse, a write was refused
);
    import lirm_pkg::*;

    // whole state of the block
    typedef struct packed {
        logic [NUM_INT-1:0][INT_W-1:0] gr;
        logic [NUM_FLT-1:0][FLT_W-1:0] fr;
        logic [INT_W-1:0] ip;
        logic [INT_W-1:0] int_rd;
        logic [FLT_W-1:0] flt_rd;
        logic [INT_W-1:0] leg_rd;
        logic refused;
    } lirm_state_s;

    lirm_state_s state_ff;
    lirm_state_s nxt_state;
    lirm_slot_s rd_slot;
    lirm_slot_s wr_slot;
    lirm_conv_e scr_int_conv;
    lirm_conv_e scr_flt_conv;

    // classify the scratch target of the legacy decoder
    lirm_conv u_conv (
        .int_idx_i(LEG_SCR_WR_I.idx),
        .flt_idx_i(LEG_SCR_WR_I.idx),
        .int_conv_o(scr_int_conv),
        .flt_conv_o(scr_flt_conv)
    );

    // legacy select decode for both legacy ports
    assign rd_slot = lirm_leg_slot(LEG_RD_SEL_I);
    assign wr_slot = lirm_leg_slot(LEG_WR_I.sel);

    // next state: reads see the old contents, writes land at the edge
    always_comb begin
        nxt_state = state_ff;
        nxt_state.refused = 1'b0;
        // native integer read, register zero is hardwired
        if (NAT_INT_RD_IDX_I == IDX_ZERO) begin
            nxt_state.int_rd = INT_RST;
        end else begin
            nxt_state.int_rd = state_ff.gr[NAT_INT_RD_IDX_I];
        end
        // native float read with two constant registers
        if (NAT_FLT_RD_IDX_I == FIDX_ZERO) begin
            nxt_state.flt_rd = FLT_ZERO;
        end else if (NAT_FLT_RD_IDX_I == FIDX_ONE) begin
            nxt_state.flt_rd = FLT_ONE;
        end else begin
            nxt_state.flt_rd = state_ff.fr[NAT_FLT_RD_IDX_I];
        end
        // legacy read through the mapping, unmapped selects read zero
        if (rd_slot.valid) begin
            nxt_state.leg_rd = lirm_get(state_ff.gr[rd_slot.idx], rd_slot);
        end else begin
            nxt_state.leg_rd = INT_RST;
        end
        // native integer write, only outside legacy execution
        if (NAT_INT_WR_I.en) begin
            if (LEGACY_MODE_I) begin
                nxt_state.refused = 1'b1;
            end else if (NAT_INT_WR_I.idx != IDX_ZERO) begin
                nxt_state.gr[NAT_INT_WR_I.idx] = NAT_INT_WR_I.data;
            end
        end
        // native float write, constants ignore it
        if (NAT_FLT_WR_I.en) begin
            if (LEGACY_MODE_I) begin
                nxt_state.refused = 1'b1;
            end else if (NAT_FLT_WR_I.idx > FIDX_ONE) begin
                nxt_state.fr[NAT_FLT_WR_I.idx] = NAT_FLT_WR_I.data;
            end
        end
        // legacy register write merges the field into its native word
        if (LEG_WR_I.en) begin
            if (!LEGACY_MODE_I || !wr_slot.valid) begin
                nxt_state.refused = 1'b1;
            end else begin
                nxt_state.gr[wr_slot.idx] = lirm_put(state_ff.gr[wr_slot.idx], wr_slot, LEG_WR_I.data);
            end
        end
        // legacy scratch write, accepted only on undefined registers
        if (LEG_SCR_WR_I.en) begin
            if (!LEGACY_MODE_I) begin
                nxt_state.refused = 1'b1;
            end else if (LEG_SCR_WR_I.is_float) begin
                if (scr_flt_conv == CONV_UNDEF) begin
                    nxt_state.fr[LEG_SCR_WR_I.idx] = LEG_SCR_WR_I.data;
                end else begin
                    nxt_state.refused = 1'b1;
                end
            end else if (scr_int_conv == CONV_UNDEF) begin
                nxt_state.gr[LEG_SCR_WR_I.idx] = LEG_SCR_WR_I.data[INT_W-1:0];
            end else begin
                nxt_state.refused = 1'b1;
            end
        end
        // one instruction pointer serves both sets
        if (IP_WR_I.en) begin
            nxt_state.ip = IP_WR_I.data;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from the state register
    assign NAT_INT_RD_DATA_O = state_ff.int_rd;
    assign NAT_FLT_RD_DATA_O = state_ff.flt_rd;
    assign LEG_RD_DATA_O = state_ff.leg_rd;
    assign IP_O = state_ff.ip;
    assign REFUSED_O = state_ff.refused;

    // preserved registers gathered for the check below
    logic [4*INT_W+4*FLT_W-1:0] unmod_bits;
    assign unmod_bits = {state_ff.gr[7:4], state_ff.fr[5:2]};

    // integer zero register reads zero one cycle later
    a_int_zero_read: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (NAT_INT_RD_IDX_I == IDX_ZERO) |=> (NAT_INT_RD_DATA_O == INT_RST))
        else $error("int register zero did not read zero");

    // float one register reads +1.0 one cycle later
    a_flt_one_read: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (NAT_FLT_RD_IDX_I == FIDX_ONE) ##1 (NAT_FLT_RD_IDX_I == FIDX_ZERO) |->
        (NAT_FLT_RD_DATA_O == FLT_ONE) ##1 (NAT_FLT_RD_DATA_O == FLT_ZERO))
        else $error("float constant registers read wrong");

    // preserved registers stay put across legacy execution
    a_unmod_kept: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        LEGACY_MODE_I |=> $stable(unmod_bits))
        else $error("preserved register changed during legacy execution");

    // native writes during legacy execution are refused and change nothing
    a_nat_refused: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (LEGACY_MODE_I && NAT_INT_WR_I.en && NAT_INT_WR_I.idx == IDX_UNMOD_LO) |=>
        (REFUSED_O && state_ff.gr[IDX_UNMOD_LO] == $past(state_ff.gr[IDX_UNMOD_LO])))
        else $error("native write during legacy execution not refused");

    // native writes in native mode reach legacy-state registers
    a_nat_write: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (!LEGACY_MODE_I && NAT_INT_WR_I.en && NAT_INT_WR_I.idx == IDX_LEG_GP_BASE) |=>
        (state_ff.gr[IDX_LEG_GP_BASE] == $past(NAT_INT_WR_I.data)))
        else $error("native write to legacy-state register lost");

    // accepted legacy scratch writes land on undefined registers
    a_scratch_land: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (LEGACY_MODE_I && LEG_SCR_WR_I.en && !LEG_SCR_WR_I.is_float && scr_int_conv == CONV_UNDEF) |=>
        (!REFUSED_O && state_ff.gr[$past(LEG_SCR_WR_I.idx)] == $past(LEG_SCR_WR_I.data[INT_W-1:0])))
        else $error("legacy scratch write did not land");

    // legacy scratch writes outside undefined registers are refused
    a_scratch_refuse: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (LEGACY_MODE_I && LEG_SCR_WR_I.en && !LEG_SCR_WR_I.is_float && scr_int_conv != CONV_UNDEF) |=>
        REFUSED_O)
        else $error("legacy write to non-scratch register accepted");

    // legacy accumulator lands in the low half of int 8, upper half kept
    a_gp_map: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (LEGACY_MODE_I && LEG_WR_I.en && LEG_WR_I.sel == LS_ACCUMULATOR) |=>
        (state_ff.gr[IDX_LEG_GP_BASE] == {$past(state_ff.gr[IDX_LEG_GP_BASE][INT_W-1:32]), $past(LEG_WR_I.data[31:0])}))
        else $error("legacy accumulator mapped wrong");

    // extra segment selector packs into bits 31:16 of int 16
    a_sel_pack: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (LEGACY_MODE_I && LEG_WR_I.en && LEG_WR_I.sel == LS_EXTRA_SEG_SEL) |=>
        (state_ff.gr[IDX_SEL_DATA][31:16] == $past(LEG_WR_I.data[15:0]) &&
         state_ff.gr[IDX_SEL_DATA][15:0] == $past(state_ff.gr[IDX_SEL_DATA][15:0])))
        else $error("selector packed into wrong field");

    // legacy read returns the legacy result in the next cycle
    a_leg_read: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (LEG_RD_SEL_I == LS_STACK_POINTER) |=>
        (LEG_RD_DATA_O == {32'h0, $past(state_ff.gr[IDX_LEG_SP][31:0])}))
        else $error("legacy stack pointer read wrong");

    // instruction pointer takes the write in either mode
    a_ip_shared: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        IP_WR_I.en |=> (IP_O == $past(IP_WR_I.data)))
        else $error("shared instruction pointer not updated");

    // float scratch register 6 takes legacy scratch data
    a_flt_scratch: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (LEGACY_MODE_I && LEG_SCR_WR_I.en && LEG_SCR_WR_I.is_float && LEG_SCR_WR_I.idx == FIDX_SCR_LO) |=>
        (state_ff.fr[FIDX_SCR_LO] == $past(LEG_SCR_WR_I.data) && !REFUSED_O))
        else $error("float scratch write lost");

endmodule
`default_nettype wire

// File: shared/lirm_pkg.sv
// package of constants, types and decode functions for the legacy register mapping block
package lirm_pkg;

    // register file geometry
    localparam int NUM_INT = 128;
    localparam int NUM_FLT = 128;
    localparam int INT_W = 64;
    localparam int FLT_W = 82;
    localparam int IDX_W = 7;
    localparam int LSB_W = 6;
    localparam int FW_W = 7;

    // native integer register indices used by the legacy mapping
    localparam logic [IDX_W-1:0] IDX_ZERO = 7'h00;
    localparam logic [IDX_W-1:0] IDX_SCR_A_LO = 7'h01;
    localparam logic [IDX_W-1:0] IDX_SCR_A_HI = 7'h03;
    localparam logic [IDX_W-1:0] IDX_UNMOD_LO = 7'h04;
    localparam logic [IDX_W-1:0] IDX_UNMOD_HI = 7'h07;
    localparam logic [IDX_W-1:0] IDX_LEG_GP_BASE = 7'h08;
    localparam logic [IDX_W-1:0] IDX_LEG_SP = 7'h0c;
    localparam logic [IDX_W-1:0] IDX_LEG_GP_HI = 7'h0f;
    localparam logic [IDX_W-1:0] IDX_SEL_DATA = 7'h10;
    localparam logic [IDX_W-1:0] IDX_SEL_CODE = 7'h11;
    localparam logic [IDX_W-1:0] IDX_SCR_B_LO = 7'h12;
    localparam logic [IDX_W-1:0] IDX_SCR_B_HI = 7'h17;
    localparam logic [IDX_W-1:0] IDX_DESC_EXTRA = 7'h18;
    localparam logic [IDX_W-1:0] IDX_SCR_C_LO = 7'h19;
    localparam logic [IDX_W-1:0] IDX_SCR_C_HI = 7'h1a;
    localparam logic [IDX_W-1:0] IDX_DESC_BASE = 7'h1b;
    localparam logic [IDX_W-1:0] IDX_DESC_HI = 7'h1f;
    localparam logic [IDX_W-1:0] IDX_EXEC_LO = 7'h20;

    // native float register indices
    localparam logic [IDX_W-1:0] FIDX_ZERO = 7'h00;
    localparam logic [IDX_W-1:0] FIDX_ONE = 7'h01;
    localparam logic [IDX_W-1:0] FIDX_UNMOD_LO = 7'h02;
    localparam logic [IDX_W-1:0] FIDX_UNMOD_HI = 7'h05;
    localparam logic [IDX_W-1:0] FIDX_SCR_LO = 7'h06;
    localparam logic [IDX_W-1:0] FIDX_SCR_HI = 7'h07;
    localparam logic [IDX_W-1:0] FIDX_EXEC_LO = 7'h20;

    // field geometry of legacy views
    localparam logic [FW_W-1:0] FW_GP = 7'h20;
    localparam logic [FW_W-1:0] FW_SEL = 7'h10;
    localparam logic [FW_W-1:0] FW_DESC = 7'h40;
    localparam int SEL_LSB_STEP = 16;

    // reset and constant values
    localparam logic [INT_W-1:0] INT_RST = 64'h0;
    localparam logic [FLT_W-1:0] FLT_RST = 82'h0;
    localparam logic [FLT_W-1:0] FLT_ZERO = 82'h0;
    localparam logic [FLT_W-1:0] FLT_ONE = {1'b0, 17'h0ffff, 64'h8000000000000000};

    // register conventions
    typedef enum logic [2:0] {
        CONV_CONST = 3'b000,
        CONV_LEGACY = 3'b001,
        CONV_UNDEF = 3'b010,
        CONV_SHARED = 3'b011,
        CONV_UNMOD = 3'b100,
        CONV_OUTSIDE = 3'b101
    } lirm_conv_e;

    // legacy register selects seen by the legacy decoder
    typedef enum logic [4:0] {
        LS_ACCUMULATOR = 5'b00000,
        LS_COUNT = 5'b00001,
        LS_DATA = 5'b00010,
        LS_BASE = 5'b00011,
        LS_STACK_POINTER = 5'b00100,
        LS_FRAME_POINTER = 5'b00101,
        LS_SOURCE_INDEX = 5'b00110,
        LS_DEST_INDEX = 5'b00111,
        LS_DATA_SEG_SEL = 5'b01000,
        LS_EXTRA_SEG_SEL = 5'b01001,
        LS_THIRD_SEG_SEL = 5'b01010,
        LS_FOURTH_SEG_SEL = 5'b01011,
        LS_CODE_SEG_SEL = 5'b01100,
        LS_STACK_SEG_SEL = 5'b01101,
        LS_LOCAL_TABLE_SEL = 5'b01110,
        LS_TASK_STATE_SEL = 5'b01111,
        LS_EXTRA_SEG_DESC = 5'b10000,
        LS_DATA_SEG_DESC = 5'b10001,
        LS_THIRD_SEG_DESC = 5'b10010,
        LS_FOURTH_SEG_DESC = 5'b10011,
        LS_LOCAL_TABLE_DESC = 5'b10100,
        LS_GLOBAL_TABLE_DESC = 5'b10101
    } lirm_leg_sel_e;

    // where a legacy register lives inside the native file
    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] idx;
        logic [LSB_W-1:0] lsb;
        logic [FW_W-1:0] width;
    } lirm_slot_s;

    // port carriers
    typedef struct packed {
        logic en;
        logic [IDX_W-1:0] idx;
        logic [INT_W-1:0] data;
    } lirm_int_wr_s;

    typedef struct packed {
        logic en;
        logic [IDX_W-1:0] idx;
        logic [FLT_W-1:0] data;
    } lirm_flt_wr_s;

    typedef struct packed {
        logic en;
        lirm_leg_sel_e sel;
        logic [INT_W-1:0] data;
    } lirm_leg_wr_s;

    typedef struct packed {
        logic en;
        logic is_float;
        logic [IDX_W-1:0] idx;
        logic [FLT_W-1:0] data;
    } lirm_scr_wr_s;

    typedef struct packed {
        logic en;
        logic [INT_W-1:0] data;
    } lirm_ip_wr_s;

    // map a legacy select to its native slot
    function automatic lirm_slot_s lirm_leg_slot(input lirm_leg_sel_e sel);
        lirm_slot_s s;
        logic [4:0] code;
        code = sel;
        s = '0;
        if (code <= 5'h07) begin
            s = '{1'b1, IDX_LEG_GP_BASE + {4'h0, code[2:0]}, 6'h00, FW_GP};
        end else if (code <= 5'h0f) begin
            s = '{1'b1, code[2] ? IDX_SEL_CODE : IDX_SEL_DATA, {code[1:0], 4'h0}, FW_SEL};
        end else if (code == 5'h10) begin
            s = '{1'b1, IDX_DESC_EXTRA, 6'h00, FW_DESC};
        end else if (code <= 5'h15) begin
            s = '{1'b1, IDX_DESC_BASE + {4'h0, code[2:0] - 3'h1}, 6'h00, FW_DESC};
        end
        return s;
    endfunction

    // mask of a field of the given width
    function automatic logic [INT_W-1:0] lirm_mask(input logic [FW_W-1:0] width);
        return (width == FW_DESC) ? {INT_W{1'b1}} : ((64'h1 << width) - 64'h1);
    endfunction

    // extract a legacy field, zero extended
    function automatic logic [INT_W-1:0] lirm_get(input logic [INT_W-1:0] word, input lirm_slot_s s);
        return (word >> s.lsb) & lirm_mask(s.width);
    endfunction

    // merge a legacy field into a native word, other bits kept
    function automatic logic [INT_W-1:0] lirm_put(input logic [INT_W-1:0] word, input lirm_slot_s s,
                                                  input logic [INT_W-1:0] val);
        logic [INT_W-1:0] m;
        m = lirm_mask(s.width) << s.lsb;
        return (word & ~m) | ((val << s.lsb) & m);
    endfunction

endpackage
